// *** hdl/atgc_pkg.sv ***
// Package: register map, field positions and trigger codes for the trigger group control
package atgc_pkg;
  localparam int NUM_GRP = 3;
  localparam int NUM_CH = 16;
  localparam int RES_DEPTH = 16;
  localparam int NUM_SRC = 15;
  // Register byte offsets
  localparam logic [9:0] OFS_CTRL = 10'h000;
  localparam logic [9:0] OFS_HOOKUP = 10'h004;
  localparam logic [9:0] OFS_GPIO = 10'h008;
  localparam logic [9:0] OFS_GRP_BASE = 10'h010;
  localparam logic [9:0] OFS_GRP_STRIDE = 10'h010;
  localparam logic [3:0] OFS_G_CFG = 4'h0;
  localparam logic [3:0] OFS_G_CHSEL = 4'h4;
  localparam logic [3:0] OFS_G_THR = 4'h8;
  localparam logic [3:0] OFS_G_STAT = 4'hC;
  localparam logic [9:0] OFS_RES_BASE = 10'h100;
  localparam logic [9:0] OFS_RES_STRIDE = 10'h040;
  // Control, hookup and gpio register fields
  localparam int CTRL_PD_EN = 0;
  localparam int HOOK_DEFAULT = 0;
  localparam int HOOK_ALT = 1;
  localparam int GPIO_OE = 0;
  localparam int GPIO_OUT = 1;
  localparam int GPIO_IN = 4;
  // Group config fields
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_HW_EN = 3;
  localparam int CFG_CONT = 4;
  localparam int CFG_DMA = 5;
  localparam int CFG_WID_LSB = 6;
  localparam int CFG_START = 8;
  // Threshold register fields
  localparam int THR_CNT_LSB = 0;
  localparam int THR_MCH_LSB = 8;
  localparam int THR_MAG_LSB = 16;
  // Status fields
  localparam int ST_THR = 0;
  localparam int ST_MAG = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_PEND = 3;
  localparam int ST_CNT_LSB = 8;
  // Result width codes, result limits, hookup reset value and sequencer states
  localparam logic [1:0] WID_12 = 2'h0;
  localparam logic [1:0] WID_10 = 2'h1;
  localparam logic [1:0] WID_8 = 2'h2;
  localparam logic [11:0] RES_MIN = 12'h000;
  localparam logic [11:0] RES_MAX = 12'hFFF;
  localparam logic [1:0] HOOK_RST = 2'h1;
  typedef enum logic [1:0] {ATGC_IDLE, ATGC_SCAN, ATGC_WAIT} atgc_state_t;
endpackage

// *** hdl/atgc_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module atgc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,               // Module clock
  input wire logic rst_i,               // Synchronous reset
  input wire logic [WIDTH-1:0] d_i,     // Asynchronous levels
  output logic [WIDTH-1:0] q_o          // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// *** hdl/atgc_top.sv ***
// Trigger group control: Wishbone registers, trigger maps, group sequencer, result regions
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module atgc_top #(
  parameter int CH_W = 4
) (
  input wire logic clk_i,                  // Module clock, 250 MHz
  input wire logic rst_i,                  // Synchronous reset, active high
  input wire logic wb_cyc_i,               // Wishbone cycle
  input wire logic wb_stb_i,               // Wishbone strobe
  input wire logic wb_we_i,                // Wishbone write enable
  input wire logic [9:0] wb_adr_i,         // Wishbone byte address
  input wire logic [3:0] wb_sel_i,         // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,        // Wishbone write data
  output logic [31:0] wb_dat_o,            // Wishbone read data
  output logic wb_ack_o,                   // Wishbone acknowledge
  input wire logic converter_external_event_pin_i,  // Event pad input level
  output logic converter_external_event_pin_o,      // Event pad output value
  output logic converter_external_event_pin_oe,     // Event pad output enable
  input wire logic second_converter_event_pin_i,    // Second event pad input level
  input wire logic [3:0] timer_channel_i,           // Timer channels 8,10,12,14
  input wire logic [3:0] timer_one_channel_i,       // Timer-one channels 27,17,19,11
  input wire logic [1:0] timer_two_channel_i,       // Timer-two channels 5,13
  input wire logic [1:0] gpio_port_b_i,             // Gpio port b bits 0,1
  input wire logic real_time_timer_cmp0_i,          // Compare-zero event, raw
  output logic conv_start_o,               // Core start pulse
  output logic [CH_W-1:0] conv_ch_o,       // Core channel
  input wire logic conv_done_i,            // Core done pulse
  input wire logic [11:0] conv_data_i,     // Core raw code
  input wire logic conv_below_i,           // Input at or below low_reference
  input wire logic conv_above_i,           // Input at or above high_reference
  output logic core_pwrdn_o,               // Core power-down
  output logic [2:0] grp_irq_o,            // Group interrupt levels
  output logic [2:0] dma_req_o             // Group DMA request pulses
);
  localparam int NG = atgc_pkg::NUM_GRP;
  localparam int NC = atgc_pkg::NUM_CH;
  localparam int RD = atgc_pkg::RES_DEPTH;

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus decode
  logic ctrl_pd_en_r;
  logic [1:0] hookup_r;
  logic gpio_oe_r;
  logic gpio_out_r;
  logic [8:0] cfg_r [NG];
  logic [NC-1:0] chsel_r [NG];
  logic [31:0] thr_r [NG];
  logic [NG-1:0] thr_flag_r;
  logic [NG-1:0] mag_flag_r;
  logic [NG-1:0] mag_above_r;
  logic [7:0] res_cnt_r [NG];
  logic [3:0] wr_ptr_r [NG];
  logic [CH_W+11:0] res_mem [NG][RD];
  logic [NG-1:0] pend_r;
  logic [NG-1:0] sw_start;
  logic [NG-1:0] hw_trig;
  logic [NG-1:0] stat_clr_thr;
  logic [NG-1:0] stat_clr_mag;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_nxt;
  logic [NG-1:0] busy_grp;
  logic [atgc_pkg::NUM_SRC-1:0] src_raw;
  logic [atgc_pkg::NUM_SRC-1:0] src_sync;
  logic [7:0] map_def;
  logic [7:0] map_alt;
  logic [7:0] map_sel;
  logic timer_two_13;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_pd_en_r <= 1'b0;
      hookup_r <= atgc_pkg::HOOK_RST;
      gpio_oe_r <= 1'b0;
      gpio_out_r <= 1'b0;
    end else if (bus_wr) begin
      if (wb_adr_i == atgc_pkg::OFS_CTRL) begin
        ctrl_pd_en_r <= wb_dat_i[atgc_pkg::CTRL_PD_EN];
      end
      if (wb_adr_i == atgc_pkg::OFS_HOOKUP) begin
        hookup_r <= wb_dat_i[1:0];
      end
      if (wb_adr_i == atgc_pkg::OFS_GPIO) begin
        gpio_oe_r <= wb_dat_i[atgc_pkg::GPIO_OE];
        gpio_out_r <= wb_dat_i[atgc_pkg::GPIO_OUT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_external_event_pin_o <= 1'b0;
      converter_external_event_pin_oe <= 1'b0;
    end else begin
      converter_external_event_pin_o <= gpio_out_r;
      converter_external_event_pin_oe <= gpio_oe_r;
    end
  end

  // Per-group register writes; start and status clears are write pulses
  for (genvar g = 0; g < NG; g++) begin : g_regs
    logic [9:0] base;
    logic hit;
    assign base = atgc_pkg::OFS_GRP_BASE + 10'(g) * atgc_pkg::OFS_GRP_STRIDE;
    assign hit = bus_wr & (wb_adr_i[9:4] == base[9:4]);
    assign sw_start[g] = hit & (wb_adr_i[3:0] == atgc_pkg::OFS_G_CFG)
                         & wb_dat_i[atgc_pkg::CFG_START];
    assign stat_clr_thr[g] = hit & (wb_adr_i[3:0] == atgc_pkg::OFS_G_STAT)
                             & wb_dat_i[atgc_pkg::ST_THR];
    assign stat_clr_mag[g] = hit & (wb_adr_i[3:0] == atgc_pkg::OFS_G_STAT)
                             & wb_dat_i[atgc_pkg::ST_MAG];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_r[g] <= 9'h000;
        chsel_r[g] <= '0;
        thr_r[g] <= 32'h0000_0000;
      end else if (hit) begin
        if (wb_adr_i[3:0] == atgc_pkg::OFS_G_CFG) begin
          cfg_r[g] <= {1'b0, wb_dat_i[7:0]};
        end
        if (wb_adr_i[3:0] == atgc_pkg::OFS_G_CHSEL) begin
          chsel_r[g] <= wb_dat_i[NC-1:0];
        end
        if (wb_adr_i[3:0] == atgc_pkg::OFS_G_THR) begin
          thr_r[g] <= wb_dat_i;
        end
      end
    end
  end

  // Read mux; result words formatted to the group's chosen width
  always_comb begin
    logic [1:0] rg;
    logic [3:0] ri;
    logic [CH_W+11:0] ent;
    logic [1:0] wid;
    rg = 2'(wb_adr_i[7:6]);
    ri = wb_adr_i[5:2];
    ent = '0;
    wid = atgc_pkg::WID_12;
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == atgc_pkg::OFS_CTRL) begin
      rd_nxt[atgc_pkg::CTRL_PD_EN] = ctrl_pd_en_r;
    end else if (wb_adr_i == atgc_pkg::OFS_HOOKUP) begin
      rd_nxt[1:0] = hookup_r;
    end else if (wb_adr_i == atgc_pkg::OFS_GPIO) begin
      rd_nxt[atgc_pkg::GPIO_OE] = gpio_oe_r;
      rd_nxt[atgc_pkg::GPIO_OUT] = gpio_out_r;
      rd_nxt[atgc_pkg::GPIO_IN] = src_sync[0];
    end else if (wb_adr_i[9:8] == 2'h0) begin
      for (int g = 0; g < NG; g++) begin
        if (wb_adr_i[7:4] == 4'(g + 1)) begin
          unique case (wb_adr_i[3:0])
            atgc_pkg::OFS_G_CFG: rd_nxt[7:0] = cfg_r[g][7:0];
            atgc_pkg::OFS_G_CHSEL: rd_nxt[NC-1:0] = chsel_r[g];
            atgc_pkg::OFS_G_THR: rd_nxt = thr_r[g];
            atgc_pkg::OFS_G_STAT: begin
              rd_nxt[atgc_pkg::ST_THR] = thr_flag_r[g];
              rd_nxt[atgc_pkg::ST_MAG] = mag_flag_r[g];
              rd_nxt[atgc_pkg::ST_BUSY] = busy_grp[g];
              rd_nxt[atgc_pkg::ST_PEND] = pend_r[g];
              rd_nxt[atgc_pkg::ST_CNT_LSB +: 8] = res_cnt_r[g];
            end
            default: rd_nxt = 32'h0000_0000;
          endcase
        end
      end
    end else if (wb_adr_i[9:8] == 2'h1 && rg < 2'(NG)) begin
      ent = res_mem[rg][ri];
      wid = cfg_r[rg][atgc_pkg::CFG_WID_LSB +: 2];
      rd_nxt[16 +: CH_W] = ent[12 +: CH_W];
      unique case (wid)
        atgc_pkg::WID_10: rd_nxt[9:0] = ent[11:2];
        atgc_pkg::WID_8: rd_nxt[7:0] = ent[11:4];
        default: rd_nxt[11:0] = ent[11:0];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger sources: pad-side levels, synchronised once and shared

  // Pad input side, so a driven-out pin still triggers
  assign src_raw = {timer_two_channel_i, timer_one_channel_i, second_converter_event_pin_i,
                    gpio_port_b_i, real_time_timer_cmp0_i, timer_channel_i,
                    converter_external_event_pin_i};

  atgc_sync #(.WIDTH(atgc_pkg::NUM_SRC)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(src_raw),
    .q_o(src_sync)
  );

  // src_sync: 0 pin, 1..4 timer 8/10/12/14, 5 rtt, 6..7 gpio b, 8 pin2,
  // 9..12 timer-one 27/17/19/11, 13 timer-two 5, 14 timer-two 13
  assign map_def = {src_sync[7], src_sync[6], src_sync[4], src_sync[3],
                    src_sync[5], src_sync[2], src_sync[1], src_sync[0]};
  assign map_alt = {timer_two_13, src_sync[12], src_sync[11], src_sync[10],
                    src_sync[5], src_sync[9], src_sync[13], src_sync[8]};
  // Neither code set: keep the default map rather than lose triggers
  assign map_sel = (~hookup_r[atgc_pkg::HOOK_DEFAULT] & hookup_r[atgc_pkg::HOOK_ALT])
                   ? map_alt : map_def;

  assign timer_two_13 = src_sync[atgc_pkg::NUM_SRC-1];

  for (genvar g = 0; g < NG; g++) begin : g_trig
    atgc_trig u_trig (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .src_i(map_sel),
      .sel_i(cfg_r[g][atgc_pkg::CFG_SRC_LSB +: 3]),
      .en_i(cfg_r[g][atgc_pkg::CFG_HW_EN]),
      .trig_o(hw_trig[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: one group at a time, event group first
  atgc_pkg::atgc_state_t state_r;
  logic [1:0] act_r;
  logic [CH_W-1:0] ch_r;
  logic [NG-1:0] seq_take;
  logic [NG-1:0] seq_end;
  logic res_we;
  logic [11:0] res_val;

  assign res_we = (state_r == atgc_pkg::ATGC_WAIT) & conv_done_i;
  assign res_val = conv_above_i ? atgc_pkg::RES_MAX :
                   (conv_below_i ? atgc_pkg::RES_MIN : conv_data_i);

  always_comb begin
    seq_take = '0;
    if (state_r == atgc_pkg::ATGC_IDLE) begin
      if (pend_r[0]) seq_take[0] = 1'b1;
      else if (pend_r[1]) seq_take[1] = 1'b1;
      else if (pend_r[2]) seq_take[2] = 1'b1;
    end
  end

  for (genvar g = 0; g < NG; g++) begin : g_end
    assign seq_end[g] = (act_r == 2'(g)) &&
                        ((state_r == atgc_pkg::ATGC_SCAN && !chsel_r[g][ch_r] &&
                          ch_r == CH_W'(NC - 1)) ||
                         (res_we && ch_r == CH_W'(NC - 1)));
    assign busy_grp[g] = (state_r != atgc_pkg::ATGC_IDLE) && (act_r == 2'(g));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else begin
      for (int g = 0; g < NG; g++) begin
        if (sw_start[g] || hw_trig[g] || (seq_end[g] && cfg_r[g][atgc_pkg::CFG_CONT])) begin
          pend_r[g] <= 1'b1;
        end else if (seq_take[g]) begin
          pend_r[g] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= atgc_pkg::ATGC_IDLE;
      act_r <= 2'h0;
      ch_r <= '0;
      conv_start_o <= 1'b0;
      conv_ch_o <= '0;
    end else begin
      conv_start_o <= 1'b0;
      unique case (state_r)
        atgc_pkg::ATGC_IDLE: begin
          ch_r <= '0;
          if (|seq_take) begin
            act_r <= seq_take[0] ? 2'h0 : (seq_take[1] ? 2'h1 : 2'h2);
            state_r <= atgc_pkg::ATGC_SCAN;
          end
        end
        atgc_pkg::ATGC_SCAN: begin
          if (chsel_r[act_r][ch_r]) begin
            conv_start_o <= 1'b1;
            conv_ch_o <= ch_r;
            state_r <= atgc_pkg::ATGC_WAIT;
          end else if (ch_r == CH_W'(NC - 1)) begin
            state_r <= atgc_pkg::ATGC_IDLE;
          end else begin
            ch_r <= ch_r + 1'b1;
          end
        end
        atgc_pkg::ATGC_WAIT: begin
          if (conv_done_i) begin
            ch_r <= ch_r + 1'b1;
            state_r <= (ch_r == CH_W'(NC - 1)) ? atgc_pkg::ATGC_IDLE : atgc_pkg::ATGC_SCAN;
          end
        end
      endcase
    end
  end

  // Core sleeps only when idle with nothing pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_pwrdn_o <= 1'b0;
    end else begin
      core_pwrdn_o <= ctrl_pd_en_r & (state_r == atgc_pkg::ATGC_IDLE) & ~|pend_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result regions, counters and service requests
  for (genvar g = 0; g < NG; g++) begin : g_res
    logic store;
    logic [7:0] thr_cnt;
    logic is_mag_ch;
    logic above;
    assign store = res_we & (act_r == 2'(g));
    assign thr_cnt = thr_r[g][atgc_pkg::THR_CNT_LSB +: 8];
    assign is_mag_ch = (ch_r == thr_r[g][atgc_pkg::THR_MCH_LSB +: CH_W]);
    assign above = res_val > thr_r[g][atgc_pkg::THR_MAG_LSB +: 12];

    always_ff @(posedge clk_i) begin
      if (store) begin
        res_mem[g][wr_ptr_r[g]] <= {ch_r, res_val};
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        wr_ptr_r[g] <= 4'h0;
        res_cnt_r[g] <= 8'h00;
        thr_flag_r[g] <= 1'b0;
        mag_flag_r[g] <= 1'b0;
        mag_above_r[g] <= 1'b0;
        dma_req_o[g] <= 1'b0;
        grp_irq_o[g] <= 1'b0;
      end else begin
        if (store) begin
          wr_ptr_r[g] <= wr_ptr_r[g] + 1'b1;
        end
        // A new result in the clearing cycle still counts
        if (store) begin
          res_cnt_r[g] <= stat_clr_thr[g] ? 8'h01 :
                          (res_cnt_r[g] == 8'hFF ? 8'hFF : res_cnt_r[g] + 1'b1);
        end else if (stat_clr_thr[g]) begin
          res_cnt_r[g] <= 8'h00;
        end
        if (store && thr_cnt != 8'h00 && res_cnt_r[g] + 8'h01 >= thr_cnt) begin
          thr_flag_r[g] <= 1'b1;
        end else if (stat_clr_thr[g]) begin
          thr_flag_r[g] <= 1'b0;
        end
        if (store && is_mag_ch) begin
          mag_above_r[g] <= above;
        end
        if (store && is_mag_ch && above && !mag_above_r[g]) begin
          mag_flag_r[g] <= 1'b1;
        end else if (stat_clr_mag[g]) begin
          mag_flag_r[g] <= 1'b0;
        end
        dma_req_o[g] <= store & cfg_r[g][atgc_pkg::CFG_DMA];
        grp_irq_o[g] <= ~cfg_r[g][atgc_pkg::CFG_DMA] & (thr_flag_r[g] | mag_flag_r[g]);
      end
    end
  end
endmodule

// *** hdl/atgc_trig.sv ***
// Per-group trigger source selector with rising-edge detector
`timescale 1ns/1ps
module atgc_trig (
  input wire logic clk_i,       // Module clock
  input wire logic rst_i,       // Synchronous reset
  input wire logic [7:0] src_i, // Synchronised trigger sources
  input wire logic [2:0] sel_i, // Source select
  input wire logic en_i,        // Hardware trigger enable
  output logic trig_o           // One-cycle start pulse
);
  logic prev_r;
  logic cur;

  assign cur = src_i[sel_i] & en_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
      trig_o <= 1'b0;
    end else begin
      prev_r <= cur;
      trig_o <= cur & ~prev_r;
    end
  end
endmodule

// *** tb/adc_trigger_group_control_tb.sv ***
// Self-checking bench for the trigger group control
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module adc_trigger_group_control_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lo = 0, hi = 0;
  logic [9:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic wb_ack_o, converter_external_event_pin_o, converter_external_event_pin_oe;
  wire logic second_converter_event_pin_i, converter_external_event_pin_i, real_time_timer_cmp0_i;
  wire logic [3:0] timer_channel_i, timer_one_channel_i;
  wire logic [1:0] timer_two_channel_i, gpio_port_b_i;
  logic conv_start_o, conv_done_i, conv_below_i, conv_above_i, core_pwrdn_o;
  logic [3:0] conv_ch_o;
  logic [11:0] conv_data_i, code = 0;
  logic [2:0] grp_irq_o, dma_req_o;
  logic [14:0] trg = 0;
  logic [3:0] ptr [3] = '{default: 4'h0};
  int n_mismatch = 0, cmp_count = 0, n_start = 0, n_dma = 0;
  int map_d [8] = '{0, 2, 3, 14, 4, 5, 12, 13};
  int map_a [8] = '{1, 10, 6, 14, 7, 8, 9, 11};
  assign {real_time_timer_cmp0_i, gpio_port_b_i, timer_two_channel_i, timer_one_channel_i,
    timer_channel_i, second_converter_event_pin_i, converter_external_event_pin_i} = trg;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_start += (conv_start_o === 1'b1);
    n_dma += $countones(dma_req_o);
  end
  atgc_top #(.CH_W(4)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .converter_external_event_pin_i,
    .converter_external_event_pin_o, .converter_external_event_pin_oe,
    .second_converter_event_pin_i, .timer_channel_i, .timer_one_channel_i, .timer_two_channel_i,
    .gpio_port_b_i, .real_time_timer_cmp0_i, .conv_start_o, .conv_ch_o, .conv_done_i,
    .conv_data_i, .conv_below_i, .conv_above_i, .core_pwrdn_o, .grp_irq_o, .dma_req_o);
  atgc_core_model i_core (.clk_i, .rst_i, .start_i(conv_start_o), .code_i(code), .lo_i(lo),
    .hi_i(hi), .done_o(conv_done_i), .data_o(conv_data_i), .below_o(conv_below_i),
    .above_o(conv_above_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Long enough to cover sync, take and a full 16-slot skip
  task automatic wst(input logic want, input logic [3:0] ch);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_i);
      if (conv_start_o === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    `CHK(seen, want)
    if (seen) `CHK(conv_ch_o, ch)
    if (want && !seen) end_of_test();
  endtask
  task automatic pulse(input int i);
    trg[i] <= 1'b1;
    repeat (3) @(posedge clk_i);
    trg[i] <= 1'b0;
  endtask
  function automatic logic [9:0] ga(input int g, input logic [3:0] o);
    return atgc_pkg::OFS_GRP_BASE + atgc_pkg::OFS_GRP_STRIDE * 10'(g) + {6'h00, o};
  endfunction
  function automatic logic [9:0] ra(input int g, input logic [3:0] i);
    return atgc_pkg::OFS_RES_BASE + atgc_pkg::OFS_RES_STRIDE * 10'(g) + {4'h0, i, 2'b00};
  endfunction
  function automatic logic [31:0] exp_res(logic [11:0] c, logic l, logic h, logic [1:0] w,
    logic [3:0] ch);
    logic [11:0] v;
    v = h ? atgc_pkg::RES_MAX : (l ? atgc_pkg::RES_MIN : c);
    if (w == atgc_pkg::WID_10) return {12'h000, ch, 6'h00, v[11:2]};
    if (w == atgc_pkg::WID_8) return {12'h000, ch, 8'h00, v[11:4]};
    return {12'h000, ch, 4'h0, v};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int g;
    logic [3:0] c0, c1;
    void'($urandom(32'h01a2e324));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(atgc_pkg::OFS_HOOKUP, 32'h1);
    rdchk(10'h0FC, 32'h0);
    rdchk(ga(2, atgc_pkg::OFS_G_STAT), 32'h0);
    wb(1'b1, atgc_pkg::OFS_GPIO, 32'h3);
    trg[0] <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK({converter_external_event_pin_oe, converter_external_event_pin_o}, 2'b11)
    rdchk(atgc_pkg::OFS_GPIO, 32'h13);
    trg[0] <= 1'b0;
    wb(1'b1, atgc_pkg::OFS_GPIO, 32'h0);
    $display("test registers done");
    for (int h = 0; h < 2; h++) begin
      wb(1'b1, atgc_pkg::OFS_HOOKUP, h ? 32'h2 : 32'h1);
      for (int s = 0; s < 8; s++) begin
        g = $urandom_range(2);
        c0 = 4'($urandom_range(15));
        i = h ? map_a[s] : map_d[s];
        {code, lo, hi} <= {12'($urandom), 2'($urandom_range(2))};
        wb(1'b1, ga(g, atgc_pkg::OFS_G_CHSEL), 32'h1 << c0);
        wb(1'b1, ga(g, atgc_pkg::OFS_G_CFG), {28'h0, 1'b1, 3'(s)});
        pulse((i + 1) % 15);
        wst(1'b0, c0);
        pulse(i);
        wst(1'b1, c0);
        wst(1'b0, c0);
        rdchk(ra(g, ptr[g]), exp_res(code, lo, hi, atgc_pkg::WID_12, c0));
        ptr[g]++;
        wb(1'b1, ga(g, atgc_pkg::OFS_G_CFG), 32'h0);
      end
    end
    $display("test trigger maps done");
    for (int w = 0; w < 3; w++) begin
      g = $urandom_range(2);
      c0 = 4'($urandom_range(14));
      c1 = 4'($urandom_range(15, c0 + 1));
      {code, lo, hi} <= {12'($urandom), 2'($urandom_range(2))};
      i = n_dma;
      wb(1'b1, ga(g, atgc_pkg::OFS_G_STAT), 32'h3);
      wb(1'b1, ga(g, atgc_pkg::OFS_G_THR), 32'h2);
      wb(1'b1, ga(g, atgc_pkg::OFS_G_CHSEL), (32'h1 << c0) | (32'h1 << c1));
      wb(1'b1, ga(g, atgc_pkg::OFS_G_CFG), {23'h0, 1'b1, 2'(w), w == 2, 5'h00});
      wst(1'b1, c0);
      wst(1'b1, c1);
      wst(1'b0, c1);
      `CHK(grp_irq_o[g], w != 2)
      `CHK(n_dma - i, (w == 2) ? 2 : 0)
      rdchk(ra(g, ptr[g]), exp_res(code, lo, hi, 2'(w), c0));
      rdchk(ra(g, ptr[g] + 4'h1), exp_res(code, lo, hi, 2'(w), c1));
      ptr[g] += 4'h2;
      wb(1'b1, ga(g, atgc_pkg::OFS_G_STAT), 32'h3);
      repeat (3) @(posedge clk_i);
      `CHK(grp_irq_o[g], 1'b0)
    end
    $display("test widths done");
    wb(1'b1, atgc_pkg::OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk_i);
    `CHK(core_pwrdn_o, 1'b1)
    wb(1'b1, ga(0, atgc_pkg::OFS_G_CHSEL), 32'h1 << c0);
    i = n_start;
    wb(1'b1, ga(0, atgc_pkg::OFS_G_CFG), 32'h110);
    repeat (100) @(posedge clk_i);
    `CHK(n_start - i > 2, 1'b1)
    wb(1'b1, ga(0, atgc_pkg::OFS_G_CFG), 32'h0);
    repeat (40) @(posedge clk_i);
    i = n_start;
    repeat (40) @(posedge clk_i);
    `CHK(n_start - i, 0)
    `CHK(core_pwrdn_o, 1'b1)
    $display("test continuous done");
    end_of_test();
  end
endmodule

// *** tb/atgc_asserts.sv ***
// Port-level assertions for the trigger group control, bound to its top
`timescale 1ns/1ps
module atgc_asserts #(
  parameter int CH_W = 4
) (
  input wire logic clk_i,                 // Clock
  input wire logic rst_i,                 // Reset
  input wire logic wb_cyc_i,              // Bus cycle
  input wire logic wb_stb_i,              // Bus strobe
  input wire logic [31:0] wb_dat_o,       // Read data
  input wire logic wb_ack_o,              // Acknowledge
  input wire logic conv_start_o,          // Core start
  input wire logic [CH_W-1:0] conv_ch_o,  // Core channel
  input wire logic conv_done_i,           // Core done
  input wire logic core_pwrdn_o,          // Core power-down
  input wire logic [2:0] grp_irq_o,       // Group interrupts
  input wire logic [2:0] dma_req_o        // Group DMA requests
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic busy_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Set between a start and its done, so a second start in flight is seen
  always_ff @(posedge clk_i) begin
    if (rst_i || conv_done_i) begin
      busy_r <= 1'b0;
    end else if (conv_start_o) begin
      busy_r <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("No ack one cycle after a request");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("Ack without a request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("Read data outside the ack cycle");
  AST_START_ALONE: assert property (conv_start_o |-> !busy_r)
    else $error("Start while a conversion is in flight");
  AST_CH_HOLD: assert property (!conv_start_o |-> $stable(conv_ch_o))
    else $error("Channel moved without a start");
  AST_PD_AWAKE: assert property (conv_start_o || busy_r |-> !core_pwrdn_o)
    else $error("Core powered down during a conversion");
  AST_DMA_CAUSE: assert property (dma_req_o != 3'h0 |-> $past(conv_done_i))
    else $error("DMA request without a stored result");
  AST_DMA_PULSE: assert property (dma_req_o != 3'h0 |=> dma_req_o == 3'h0)
    else $error("DMA request longer than one cycle");
  AST_IRQ_DMA: assert property ((grp_irq_o & dma_req_o) == 3'h0)
    else $error("Interrupt and DMA on one group");
  AST_IRQ_RISE: assert property ((grp_irq_o & ~$past(grp_irq_o)) != 3'h0 |-> $past(conv_done_i, 2))
    else $error("Interrupt rose without a result two cycles earlier");
endmodule

bind atgc_top atgc_asserts #(.CH_W(CH_W)) i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .conv_start_o, .conv_ch_o, .conv_done_i, .core_pwrdn_o, .grp_irq_o,
  .dma_req_o);

// *** tb/atgc_core_model.sv ***
// Behavioural conversion core: one done per start after a random delay
`timescale 1ns/1ps
module atgc_core_model (
  input wire logic clk_i,       // Clock
  input wire logic rst_i,       // Reset
  input wire logic start_i,     // Start pulse
  input wire logic [11:0] code_i, // Code to return
  input wire logic lo_i,        // Input at low rail
  input wire logic hi_i,        // Input at high rail
  output logic done_o,          // Done pulse
  output logic [11:0] data_o,   // Raw code
  output logic below_o,         // Below flag
  output logic above_o          // Above flag
);
  int cnt = 0;
  initial {done_o, data_o, below_o, above_o} = {1'b0, 12'hA5A, 2'b01};
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    // Stale outputs toggle so they never pass for a valid answer
    data_o <= ~data_o;
    {below_o, above_o} <= {above_o, ~below_o};
    if (rst_i) begin
      cnt <= 0;
    end else if (start_i) begin
      cnt <= 1 + $urandom_range(3);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        done_o <= 1'b1;
        data_o <= code_i;
        {below_o, above_o} <= {lo_i, hi_i};
      end
    end
  end
endmodule
